//--- rtl/ocg_defs.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 overcurrent/overvoltage guard. Assumes inclusion by bare name.
*/
`ifndef OCG_DEFS_SVH
`define OCG_DEFS_SVH

`define OCG_OFS_CURRENT_TRIP 8'h00
`define OCG_OFS_VOLTAGE_TRIP 8'h04
`define OCG_OFS_ENABLES 8'h08
`define OCG_OFS_SENSE_MODE 8'h0C
`define OCG_OFS_AMP_TRIM 8'h10
`define OCG_OFS_VCMP_TRIM 8'h14
`define OCG_OFS_CCMP_TRIM 8'h18
`define OCG_OFS_STATUS 8'h1C
`define OCG_OFS_FAULT 8'h20

`define OCG_BIT_CUR_MASTER 7
`define OCG_BIT_VOL_MASTER 6
`define OCG_BIT_CUR_LOW 5
`define OCG_BIT_CUR_HIGH 4
`define OCG_BIT_VOL_LOW 3
`define OCG_BIT_VOL_HIGH 2
`define OCG_BIT_CUR_HYST 1
`define OCG_BIT_VOL_HYST 0

`define OCG_BIT_AMP_POL 7
`define OCG_BIT_VPIN_EN 6
`define OCG_BIT_CPIN_EN 5
`define OCG_SENSE_MODE_MASK 8'hEF
`define OCG_VOLTAGE_TRIP_MASK 8'h3F

`define OCG_RST_ZERO 8'h00
`define OCG_RST_TRIM 8'h20

`define OCG_DB_SHORT 7'h10
`define OCG_DB_MID 7'h20
`define OCG_DB_LONG 7'h40

`define OCG_RESP_OKAY 2'b00
`define OCG_RESP_SLVERR 2'b10

`endif

//--- rtl/ocg_guard.sv
/*
 Digital control of the battery overcurrent/overvoltage guard: AXI4-Lite
 register file, comparator synchronisers and debounce, drive override.
 Assumes the comparator outputs are asynchronous and the PWM source is on
 ref_clk ahead of the polarity stage.
*/
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ocg_defs.svh"

module ocg_guard
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // AXI4-Lite write address, data and response
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog sense results, asynchronous
   input wire ocg_pkg::ocg_sense_s sense_async,
   // PWM source and guarded drive
   input wire ocg_pkg::ocg_drive_s pwm_drive,
   output ocg_pkg::ocg_drive_s guarded_drive,
   // Analog control
   output logic [7:0] current_trip_code,
   output logic [5:0] voltage_trip_code,
   output logic current_comparator_hyst_en,
   output logic voltage_comparator_hyst_en,
   output logic amplifier_polarity_sel,
   output logic voltage_pin_en,
   output logic current_pin_en,
   output logic [7:0] amplifier_offset_trim,
   output logic [7:0] voltage_comparator_trim,
   output logic [7:0] current_comparator_trim,
   output ocg_pkg::ocg_power_s power_down,
   // Fault requests, one-cycle pulses
   output logic voltage_fault_irq,
   output logic current_fault_irq
);
   import ocg_pkg::*;

   // Register state
   logic [7:0] current_trip_level, next_current_trip_level;
   logic [7:0] voltage_trip_level, next_voltage_trip_level;
   logic [7:0] protection_enables, next_protection_enables;
   logic [7:0] sense_mode_and_debounce, next_sense_mode_and_debounce;
   logic [7:0] amp_trim, next_amp_trim, vcmp_trim, next_vcmp_trim;
   logic [7:0] ccmp_trim, next_ccmp_trim;

   // Bus state
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;

   // Sense path state
   ocg_sense_s sync1, sync2;
   logic [6:0] v_cnt, next_v_cnt, c_cnt, next_c_cnt;
   logic v_level, next_v_level, c_level, next_c_level;
   logic v_fault, c_fault, v_fault_q, c_fault_q;
   ocg_drive_s next_drive;

   logic cur_master, vol_master, do_write;
   logic [31:0] rd_word;

   function automatic logic [6:0] db_len(input logic [1:0] sel);
      db_len = 7'h00;
      unique case (ocg_db_e'(sel))
         OCG_DB_NONE: db_len = 7'h00;
         OCG_DB_16: db_len = `OCG_DB_SHORT;
         OCG_DB_32: db_len = `OCG_DB_MID;
         OCG_DB_64: db_len = `OCG_DB_LONG;
      endcase
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
      return strb[0] ? data[7:0] : old;
   endfunction

   assign cur_master = protection_enables[`OCG_BIT_CUR_MASTER];
   assign vol_master = protection_enables[`OCG_BIT_VOL_MASTER];

   // Synchroniser; first stage feeds only the second
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= sense_async;
         sync2 <= sync1;
      end
   end

   // Debounce: level moves only after raw input stays different long enough
   always_comb
   begin
      next_v_cnt = 7'd0;
      next_c_cnt = 7'd0;
      next_v_level = v_level;
      next_c_level = c_level;
      if (sync2.voltage_comparator_out != v_level)
      begin
         next_v_cnt = v_cnt + 7'd1;
         if (v_cnt + 7'd1 >= db_len(sense_mode_and_debounce[1:0]))
         begin
            next_v_level = sync2.voltage_comparator_out;
            next_v_cnt = 7'd0;
         end
      end
      if (sync2.current_comparator_out != c_level)
      begin
         next_c_cnt = c_cnt + 7'd1;
         if (c_cnt + 7'd1 >= db_len(sense_mode_and_debounce[3:2]))
         begin
            next_c_level = sync2.current_comparator_out;
            next_c_cnt = 7'd0;
         end
      end
   end

   // Faults and drive override, ahead of the polarity stage
   always_comb
   begin
      v_fault = vol_master && next_v_level;
      c_fault = cur_master && next_c_level;
      next_drive = pwm_drive;
      if ((c_fault && protection_enables[`OCG_BIT_CUR_HIGH]) ||
          (v_fault && protection_enables[`OCG_BIT_VOL_HIGH]))
         next_drive.high_side_drive = 1'b1;
      if ((c_fault && protection_enables[`OCG_BIT_CUR_LOW]) ||
          (v_fault && protection_enables[`OCG_BIT_VOL_LOW]))
         next_drive.low_side_drive = 1'b0;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         v_cnt <= 7'd0;
         c_cnt <= 7'd0;
         v_level <= 1'b0;
         c_level <= 1'b0;
         v_fault_q <= 1'b0;
         c_fault_q <= 1'b0;
         guarded_drive <= '0;
      end
      else
      begin
         v_cnt <= next_v_cnt;
         c_cnt <= next_c_cnt;
         v_level <= next_v_level;
         c_level <= next_c_level;
         v_fault_q <= v_fault;
         c_fault_q <= c_fault;
         guarded_drive <= next_drive;
      end
   end

   // Request pulses on the onset of each fault type
   assign voltage_fault_irq = v_fault && !v_fault_q;
   assign current_fault_irq = c_fault && !c_fault_q;

   // Read mux; unused bits read zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr)
         `OCG_OFS_CURRENT_TRIP: rd_word[7:0] = current_trip_level;
         `OCG_OFS_VOLTAGE_TRIP: rd_word[7:0] = voltage_trip_level;
         `OCG_OFS_ENABLES: rd_word[7:0] = protection_enables;
         `OCG_OFS_SENSE_MODE: rd_word[7:0] = sense_mode_and_debounce;
         `OCG_OFS_AMP_TRIM: rd_word[7:0] = amp_trim;
         `OCG_OFS_VCMP_TRIM: rd_word[7:0] = vcmp_trim;
         `OCG_OFS_CCMP_TRIM: rd_word[7:0] = ccmp_trim;
         `OCG_OFS_STATUS: rd_word[2:0] = sync2;
         `OCG_OFS_FAULT: rd_word[1:0] = {c_fault_q, v_fault_q};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Bus slave

   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid && !s_axi_bready;
      next_bresp = bresp;
      next_rvalid = rvalid && !s_axi_rready;
      next_rresp = rresp;
      next_rdata = rdata;
      next_current_trip_level = current_trip_level;
      next_voltage_trip_level = voltage_trip_level;
      next_protection_enables = protection_enables;
      next_sense_mode_and_debounce = sense_mode_and_debounce;
      next_amp_trim = amp_trim;
      next_vcmp_trim = vcmp_trim;
      next_ccmp_trim = ccmp_trim;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      // Pair complete once both halves are in, this cycle or earlier
      do_write = next_aw_held && next_w_held && !bvalid;
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = `OCG_RESP_OKAY;
         unique case (next_aw_addr)
            `OCG_OFS_CURRENT_TRIP: next_current_trip_level = merge(
               current_trip_level, next_w_data, next_w_strb);
            `OCG_OFS_VOLTAGE_TRIP: next_voltage_trip_level = merge(
               voltage_trip_level, next_w_data, next_w_strb)
               & `OCG_VOLTAGE_TRIP_MASK;
            `OCG_OFS_ENABLES: next_protection_enables = merge(
               protection_enables, next_w_data, next_w_strb);
            `OCG_OFS_SENSE_MODE: next_sense_mode_and_debounce = merge(
               sense_mode_and_debounce, next_w_data, next_w_strb)
               & `OCG_SENSE_MODE_MASK;
            `OCG_OFS_AMP_TRIM: next_amp_trim = merge(
               amp_trim, next_w_data, next_w_strb);
            `OCG_OFS_VCMP_TRIM: next_vcmp_trim = merge(
               vcmp_trim, next_w_data, next_w_strb);
            `OCG_OFS_CCMP_TRIM: next_ccmp_trim = merge(
               ccmp_trim, next_w_data, next_w_strb);
            default: next_bresp = `OCG_RESP_SLVERR;
         endcase
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rdata = rd_word;
         next_rresp = (s_axi_araddr <= `OCG_OFS_FAULT &&
                       s_axi_araddr[1:0] == 2'b00) ?
                      `OCG_RESP_OKAY : `OCG_RESP_SLVERR;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `OCG_RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= `OCG_RESP_OKAY;
         rdata <= 32'h0000_0000;
         current_trip_level <= `OCG_RST_ZERO;
         voltage_trip_level <= `OCG_RST_ZERO;
         protection_enables <= `OCG_RST_ZERO;
         sense_mode_and_debounce <= `OCG_RST_ZERO;
         amp_trim <= `OCG_RST_TRIM;
         vcmp_trim <= `OCG_RST_TRIM;
         ccmp_trim <= `OCG_RST_TRIM;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         current_trip_level <= next_current_trip_level;
         voltage_trip_level <= next_voltage_trip_level;
         protection_enables <= next_protection_enables;
         sense_mode_and_debounce <= next_sense_mode_and_debounce;
         amp_trim <= next_amp_trim;
         vcmp_trim <= next_vcmp_trim;
         ccmp_trim <= next_ccmp_trim;
      end
   end

   // Holding a half write stalls that channel until the pair completes and its response is taken
   assign s_axi_awready = !aw_held && !bvalid;
   assign s_axi_wready = !w_held && !bvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;

   // Analog control; polarity is software's choice per charge direction
   assign current_trip_code = current_trip_level;
   assign voltage_trip_code = voltage_trip_level[5:0];
   assign current_comparator_hyst_en =
      protection_enables[`OCG_BIT_CUR_HYST];
   assign voltage_comparator_hyst_en =
      protection_enables[`OCG_BIT_VOL_HYST];
   assign amplifier_polarity_sel =
      sense_mode_and_debounce[`OCG_BIT_AMP_POL];
   assign voltage_pin_en = sense_mode_and_debounce[`OCG_BIT_VPIN_EN];
   assign current_pin_en = sense_mode_and_debounce[`OCG_BIT_CPIN_EN];
   assign amplifier_offset_trim = amp_trim;
   assign voltage_comparator_trim = vcmp_trim;
   assign current_comparator_trim = ccmp_trim;
   assign power_down = {{3{!cur_master}}, {2{!vol_master}}};
endmodule
`default_nettype wire

//--- rtl/ocg_pkg.sv
/*
 Types for the overcurrent/overvoltage guard. Assumes the defs header
 carries the numbers.
*/
package ocg_pkg;
   typedef struct packed {
      logic high_side_drive;
      logic low_side_drive;
   } ocg_drive_s;

   typedef struct packed {
      logic amplifier_logic_out;
      logic current_comparator_out;
      logic voltage_comparator_out;
   } ocg_sense_s;

   typedef struct packed {
      logic current_amp_pd;
      logic current_cmp_pd;
      logic current_dac_pd;
      logic voltage_cmp_pd;
      logic voltage_dac_pd;
   } ocg_power_s;

   typedef enum logic [1:0] {
      OCG_DB_NONE,
      OCG_DB_16,
      OCG_DB_32,
      OCG_DB_64
   } ocg_db_e;
endpackage

//--- sim/ocg_analog_model.sv
/*
 Analog side model: comparators, amplifier and PWM source.
 Assumes the bench sets the wanted sense levels.
*/
`timescale 1ns/1ps
`default_nettype none
module ocg_analog_model
   import ocg_pkg::*;
(
   // Clock and wanted levels
   input wire logic ref_clk,
   input wire logic v_hi,
   input wire logic c_hi,
   input wire logic a_hi,
   // Toward the guard
   output var ocg_pkg::ocg_drive_s pwm_drive,
   output var ocg_pkg::ocg_sense_s sense_async
);
   logic [2:0] cnt = 3'h0;
   initial sense_async = 3'h0;
   always @(posedge ref_clk)
      cnt <= cnt + 3'h1;
   // Both bits vary so every override shows
   always_comb
      pwm_drive = {cnt[1], cnt[2]};
   // Comparators settle off the clock edge, unrelated to it
   always @(v_hi, c_hi, a_hi)
      sense_async <= #1.7 {a_hi, c_hi, v_hi};
endmodule
`default_nettype wire

//--- sim/ocg_guard_asserts.sv
/*
 Checker of bus answers, fault requests and the drive override.
 Assumes it is bound into ocg_guard.
*/
`timescale 1ns/1ps
`default_nettype none
module ocg_guard_asserts
   import ocg_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Drive and faults
   input wire ocg_pkg::ocg_drive_s pwm_drive,
   input wire ocg_pkg::ocg_drive_s guarded_drive,
   input wire ocg_pkg::ocg_power_s power_down,
   input wire logic voltage_fault_irq,
   input wire logic current_fault_irq
);
   logic [1:0] live;
   logic [1:0] next_live;
   // Keeps $past away from values taken during reset
   always_comb
      next_live = (live == 2'h2) ? live : live + 2'h1;
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
         live <= 2'h0;
      else
         live <= next_live;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("no write answer");
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read answer moved");
   property p_v_pulse;
      voltage_fault_irq |=> !voltage_fault_irq;
   endproperty
   a_v_pulse: assert property (p_v_pulse)
      else $error("request too long");
   property p_c_gate;
      current_fault_irq |-> power_down[4:2] == 3'h0;
   endproperty
   a_c_gate: assert property (p_c_gate)
      else $error("current off yet fault");
   property p_v_gate;
      voltage_fault_irq |-> power_down[1:0] == 2'h0;
   endproperty
   a_v_gate: assert property (p_v_gate)
      else $error("voltage off yet fault");
   property p_pd_group;
      power_down[4:2] inside {3'h0, 3'h7} &&
         power_down[1:0] inside {2'h0, 2'h3};
   endproperty
   a_pd_group: assert property (p_pd_group)
      else $error("split power-down");
   property p_high_dir;
      live == 2'h2 && guarded_drive[1] != $past(pwm_drive[1])
         |-> guarded_drive[1];
   endproperty
   a_high_dir: assert property (p_high_dir)
      else $error("high side forced low");
   property p_low_dir;
      live == 2'h2 && guarded_drive[0] != $past(pwm_drive[0])
         |-> !guarded_drive[0];
   endproperty
   a_low_dir: assert property (p_low_dir)
      else $error("low side forced high");
   property p_follow;
      live == 2'h2 && $past(power_down[3]) && $past(power_down[1])
         |-> guarded_drive == $past(pwm_drive);
   endproperty
   a_follow: assert property (p_follow)
      else $error("drive not following");
   c_v_irq: cover property (voltage_fault_irq);
   c_c_irq: cover property (current_fault_irq);
   c_forced: cover property (live == 2'h2 &&
      guarded_drive != $past(pwm_drive));
endmodule
bind ocg_guard ocg_guard_asserts i_chk (.ref_clk, .reset_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pwm_drive,
   .guarded_drive, .power_down, .voltage_fault_irq, .current_fault_irq);
`default_nettype wire

//--- sim/tb.sv
/*
 Self-checking bench of the guard: registers, faults, debounce.
 Assumes the analog model drives sense and PWM.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ocg_pkg::*;
   logic ref_clk, reset_n, v_hi, c_hi, a_hi;
   logic [7:0] s_axi_awaddr, s_axi_araddr, current_trip_code;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, voltage_fault_irq, current_fault_irq;
   logic [1:0] hyst;
   logic [2:0] mode_pins;
   logic [23:0] trims;
   logic [5:0] voltage_trip_code;
   ocg_sense_s sense_async;
   ocg_drive_s pwm_drive, guarded_drive;
   ocg_power_s power_down;
   int error_cnt, samples_checked;
   ocg_guard i_dut (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense_async, .pwm_drive,
      .guarded_drive, .current_trip_code, .voltage_trip_code,
      .current_comparator_hyst_en(hyst[1]),
      .voltage_comparator_hyst_en(hyst[0]),
      .amplifier_polarity_sel(mode_pins[2]),
      .voltage_pin_en(mode_pins[1]), .current_pin_en(mode_pins[0]),
      .amplifier_offset_trim(trims[23:16]),
      .voltage_comparator_trim(trims[15:8]),
      .current_comparator_trim(trims[7:0]), .power_down, .voltage_fault_irq,
      .current_fault_irq);
   ocg_analog_model i_ana (.ref_clk, .v_hi, .c_hi, .a_hi, .pwm_drive,
      .sense_async);
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      logic ta, tw, tk;
      logic [1:0] rs;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      repeat (40)
      begin
         @(negedge ref_clk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tk = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge ref_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tk)
         begin
            s_axi_bready <= 1'b0;
            chk(rs, r);
            return;
         end
      end
      chk(1'b0, 1'b1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      logic ta, tk;
      logic [1:0] rs;
      logic [31:0] rv;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      repeat (40)
      begin
         @(negedge ref_clk);
         ta = s_axi_arvalid & s_axi_arready;
         tk = s_axi_rvalid;
         rs = s_axi_rresp;
         rv = s_axi_rdata;
         @(posedge ref_clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tk)
         begin
            s_axi_rready <= 1'b0;
            chk(rv, e);
            chk(rs, r);
            return;
         end
      end
      chk(1'b0, 1'b1);
   endtask
   // Drive against last cycle's PWM, with the forced sides
   task automatic follow(input logic fh, input logic fl);
      ocg_drive_s p, e;
      @(negedge ref_clk);
      p = pwm_drive;
      repeat (8)
      begin
         @(negedge ref_clk);
         e = p;
         if (fh) e.high_side_drive = 1'b1;
         if (fl) e.low_side_drive = 1'b0;
         chk(guarded_drive, e);
         p = pwm_drive;
      end
   endtask
   task automatic lat(input logic cur, input int m, output int n);
      n = 0;
      while (n < m)
      begin
         @(negedge ref_clk);
         n++;
         if (cur ? current_fault_irq === 1'b1 : voltage_fault_irq === 1'b1)
            return;
      end
   endtask
   task automatic t_regs;
      rd(8'h00, 32'h0, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      chk(power_down, 5'h1F);
      chk(trims, 24'h202020);
      wr(8'h10, 8'h5A, 2'h0);
      rd(8'h10, 32'h5A, 2'h0);
      chk(trims, 24'h5A2020);
      wr(8'h0C, 8'hFF, 2'h0);
      rd(8'h0C, 32'hEF, 2'h0);
      chk(mode_pins, 3'h7);
      wr(8'h0C, 8'h00, 2'h0);
      wr(8'h00, 8'hA5, 2'h0);
      rd(8'h00, 32'hA5, 2'h0);
      chk(current_trip_code, 8'hA5);
      wr(8'h04, 8'hFF, 2'h0);
      rd(8'h04, 32'h3F, 2'h0);
      chk(voltage_trip_code, 6'h3F);
      wr(8'h08, 8'h02, 2'h0);
      chk(hyst, 2'h2);
      wr(8'h08, 8'h01, 2'h0);
      chk(hyst, 2'h1);
      wr(8'h1C, 8'hFF, 2'h2);
      rd(8'h40, 32'h0, 2'h2);
   endtask
   task automatic t_volt;
      int n;
      wr(8'h08, 8'h4C, 2'h0);
      v_hi <= 1'b1;
      lat(1'b0, 20, n);
      chk(n >= 2 && n <= 6, 1'b1);
      follow(1'b1, 1'b1);
      rd(8'h1C, 32'h1, 2'h0);
      rd(8'h20, 32'h1, 2'h0);
      wr(8'h08, 8'h44, 2'h0);
      follow(1'b1, 1'b0);
      wr(8'h08, 8'h48, 2'h0);
      follow(1'b0, 1'b1);
      v_hi <= 1'b0;
      repeat (6) @(posedge ref_clk);
      follow(1'b0, 1'b0);
   endtask
   task automatic t_cur;
      int n;
      wr(8'h08, 8'hA0, 2'h0);
      c_hi <= 1'b1;
      a_hi <= 1'b1;
      lat(1'b1, 20, n);
      chk(n >= 2 && n <= 6, 1'b1);
      follow(1'b0, 1'b1);
      rd(8'h1C, 32'h6, 2'h0);
      rd(8'h20, 32'h2, 2'h0);
      wr(8'h08, 8'h90, 2'h0);
      follow(1'b1, 1'b0);
      wr(8'h08, 8'h3C, 2'h0);
      v_hi <= 1'b1;
      follow(1'b0, 1'b0);
      chk(power_down, 5'h1F);
      lat(1'b1, 30, n);
      chk(n, 30);
      {v_hi, c_hi, a_hi} <= 3'h0;
   endtask
   task automatic t_deb;
      int n;
      int lo[4] = '{2, 16, 32, 64};
      wr(8'h08, 8'h4C, 2'h0);
      wr(8'h0C, 8'h81, 2'h0);
      chk(mode_pins, 3'h4);
      v_hi <= 1'b1;
      lat(1'b0, 10, n);
      chk(n, 10);
      @(posedge ref_clk);
      v_hi <= 1'b0;
      lat(1'b0, 40, n);
      chk(n, 40);
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h0C, {6'h20, s[1:0]}, 2'h0);
         v_hi <= 1'b1;
         lat(1'b0, 100, n);
         chk(n >= lo[s] && n <= lo[s] + 8, 1'b1);
         @(posedge ref_clk);
         v_hi <= 1'b0;
         repeat (80) @(posedge ref_clk);
      end
   endtask
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      {reset_n, v_hi, c_hi, a_hi} = 4'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_regs;
      t_volt;
      t_cur;
      t_deb;
      close_out;
   end
   initial
   begin
      #100000;
      error_cnt++;
      close_out;
   end
endmodule
`default_nettype wire
